//--- sim/eas_di_model.sv
// Switch model for the start and stop inputs of the sequencer block.
// Assumes the bench moves start_cmd and stop_cmd just after mclk edges.
`timescale 1ns/1ns
`default_nettype none
module eas_di_model #(
   parameter int LAG = 2
) (
   input wire logic mclk,
   input wire logic start_cmd,
   input wire logic stop_cmd,
   output logic di_start,
   output logic di_stop
);
   logic [LAG-1:0] st_q = '0;
   logic [LAG-1:0] sp_q = '0;
   // Contacts settle late; block must not need same-cycle inputs
   always_ff @(posedge mclk) begin
      st_q <= {st_q[LAG-2:0], start_cmd};
      sp_q <= {sp_q[LAG-2:0], stop_cmd};
   end
   assign di_start = st_q[LAG-1];
   // Stop contact is active low, line pulled high when open
   assign di_stop = ~sp_q[LAG-1];
endmodule
`default_nettype wire

//--- sim/eas_top_tb_top.sv
// Self-checking bench for the event/action sequencer.
// Assumes eas_pkg, eas_top and the switch model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module eas_top_tb_top;
   localparam int SCAN = 8;
   localparam logic [7:0] EVS [4] = '{eas_pkg::EV_FALSE, eas_pkg::EV_ON_REF,
      eas_pkg::EV_TIMEOUT0, eas_pkg::EV_FALSE};
   localparam logic [7:0] ACTS [4] = '{eas_pkg::ACT_PRESET0,
      eas_pkg::ACT_TIMER0, eas_pkg::ACT_PRESET1, eas_pkg::ACT_NONE};
   logic mclk, arst_n, wr_en, rd_en, at_reference, ramp_done;
   logic start_cmd, stop_cmd, di_start, di_stop;
   logic preset_sel, run_cmd, ramp_down, coast, action_pulse;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, rv;
   int mismatches, cmp_count, pulses, p0;

   eas_top #(.SCAN_CYCLES(SCAN)) dut (.mclk(mclk), .arst_n(arst_n),
      .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .rdata(rdata), .di_start(di_start), .di_stop(di_stop),
      .at_reference(at_reference), .ramp_done(ramp_done),
      .preset_sel(preset_sel), .run_cmd(run_cmd), .ramp_down(ramp_down),
      .coast(coast), .action_pulse(action_pulse));
   eas_di_model sw (.mclk(mclk), .start_cmd(start_cmd),
      .stop_cmd(stop_cmd), .di_start(di_start), .di_stop(di_stop));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) if (action_pulse === 1'b1) pulses++;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd_en <= 1'b0;
      @(posedge mclk);
      rv = rdata;
   endtask
   task automatic wait_pulse();
      int n;
      n = pulses;
      for (int i = 0; i < 100 && pulses == n; i++) @(posedge mclk);
      // A pulse that never comes counts as a failure
      if (pulses == n) mismatches++;
   endtask
   task automatic summarize();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #100000;
      mismatches++;
      summarize();
   end

   initial begin
      mismatches = 0;
      cmp_count = 0;
      pulses = 0;
      arst_n = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      at_reference = 1'b0;
      ramp_done = 1'b0;
      start_cmd = 1'b0;
      stop_cmd = 1'b0;
      repeat (6) @(posedge mclk);
      arst_n <= 1'b1;
      check({31'h0, coast}, 32'h1);
      rd(eas_pkg::A_STATUS);
      check(rv, 32'h0);
      rd(eas_pkg::A_TMR0);
      check(rv, 32'h0);
      rd(eas_pkg::A_DI_FUNC);
      check(rv, 32'h8);
      for (int i = 0; i < 4; i++) begin
         wr(eas_pkg::A_EVENT0 + 8'(4 * i), {24'h0, EVS[i]});
         wr(eas_pkg::A_ACTION0 + 8'(4 * i), {24'h0, ACTS[i]});
      end
      wr(eas_pkg::A_TMR0, 32'd20);
      wr(eas_pkg::A_ACTION0 + 8'h50, 32'h1d);
      rd(eas_pkg::A_ACTION0 + 8'h50);
      check(rv, 32'h0);
      wr(eas_pkg::A_CTRL, 32'h0301);
      p0 = pulses;
      repeat (4 * SCAN) @(posedge mclk);
      rd(eas_pkg::A_STATUS);
      check(rv & 32'h1f, 32'h0);
      check(32'(pulses - p0), 32'h0);
      wr(eas_pkg::A_EVENT0, {24'h0, eas_pkg::EV_TRUE});
      wait_pulse();
      rd(eas_pkg::A_STATUS);
      check(rv & 32'h9f, 32'h1);
      p0 = pulses;
      repeat (3 * SCAN) @(posedge mclk);
      rd(eas_pkg::A_STATUS);
      check(rv & 32'h1f, 32'h1);
      check(32'(pulses - p0), 32'h0);
      at_reference <= 1'b1;
      wait_pulse();
      rd(eas_pkg::A_STATUS);
      check(rv & 32'h11f, 32'h102);
      wait_pulse();
      rd(eas_pkg::A_STATUS);
      check(rv & 32'h9f, 32'h80);
      check({31'h0, preset_sel}, 32'h1);
      at_reference <= 1'b0;
      wait_pulse();
      wr(eas_pkg::A_CTRL, 32'h0300);
      rd(eas_pkg::A_STATUS);
      check(rv & 32'h1f, 32'h0);
      p0 = pulses;
      repeat (3 * SCAN) @(posedge mclk);
      check(32'(pulses - p0), 32'h0);
      wr(eas_pkg::A_CTRL, 32'h0001);
      repeat (3 * SCAN) @(posedge mclk);
      check(32'(pulses - p0), 32'h0);
      wr(eas_pkg::A_CTRL, 32'h0);
      start_cmd <= 1'b1;
      repeat (6) @(posedge mclk);
      check({31'h0, run_cmd}, 32'h1);
      start_cmd <= 1'b0;
      repeat (6) @(posedge mclk);
      check({30'h0, ramp_down, coast}, 32'h2);
      ramp_done <= 1'b1;
      repeat (6) @(posedge mclk);
      check({29'h0, run_cmd, ramp_down, coast}, 32'h1);
      ramp_done <= 1'b0;
      wr(eas_pkg::A_DI_FUNC, 32'h69);
      start_cmd <= 1'b1;
      repeat (2) @(posedge mclk);
      start_cmd <= 1'b0;
      repeat (6) @(posedge mclk);
      check({31'h0, run_cmd}, 32'h1);
      stop_cmd <= 1'b1;
      repeat (2) @(posedge mclk);
      stop_cmd <= 1'b0;
      repeat (4) @(posedge mclk);
      rd(eas_pkg::A_STATUS);
      check(rv & 32'hc00, 32'h800);
      summarize();
   end
endmodule
`default_nettype wire

//--- verilog/eas_pkg.sv
// Constants and types for the event/action sequencer.
// Assumes one 100 MHz clock and a scan tick derived inside the block.
// Overview of operation
// - A true current event runs its action, then the next pair is tested.
// - Only one event condition is tested at any time.
// - A false event does nothing; the same event is retried next scan.
// - On start only the first event is tested each scan until it is true.
// - Zero to twenty pairs are kept in indexed event and action arrays.
// - After the last programmed action the sequence wraps to the first.
// - Event codes: 0 false, 1 true, 4 at reference, 30 timer 0 expired.
// - Action codes: 1 none, 10 preset 0, 11 preset 1, 29 start timer 0.
// - Timer 0 has a set length; start arms it, expiry makes its event true.
// - The sequencer runs only while its global enable is on.
// - A start/stop input stop ramps the motor down, then coasts free.
package eas_pkg;
   localparam int MAX_PAIRS = 20;
   localparam int CODE_W = 8;
   localparam int IDX_W = 5;
   localparam int TMR_W = 32;
   // Event codes
   localparam logic [7:0] EV_FALSE = 8'h00;
   localparam logic [7:0] EV_TRUE = 8'h01;
   localparam logic [7:0] EV_ON_REF = 8'h04;
   localparam logic [7:0] EV_TIMEOUT0 = 8'h1e;
   // Action codes
   localparam logic [7:0] ACT_NONE = 8'h01;
   localparam logic [7:0] ACT_PRESET0 = 8'h0a;
   localparam logic [7:0] ACT_PRESET1 = 8'h0b;
   localparam logic [7:0] ACT_TIMER0 = 8'h1d;
   // Digital input function codes
   localparam logic [3:0] DI_NOOP = 4'h0;
   localparam logic [3:0] DI_STOP_INV = 4'h6;
   localparam logic [3:0] DI_START = 4'h8;
   localparam logic [3:0] DI_LATCH_START = 4'h9;
   // Scan interval and register map
   localparam int CLK_HZ = 100_000_000;
   localparam int SCAN_US = 1000;
   localparam int SCAN_CYC = SCAN_US * (CLK_HZ / 1_000_000);
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_TMR0 = 8'h08;
   localparam logic [7:0] A_DI_FUNC = 8'h0c;
   localparam logic [7:0] A_EVENT0 = 8'h40;
   localparam logic [7:0] A_ACTION0 = 8'ha0;
   localparam logic [3:0] DI18_RST = 4'h8;
   localparam logic [3:0] DI27_RST = 4'h0;
   typedef enum logic [1:0] {
      MOT_FREE = 2'b00,
      MOT_RUN = 2'b01,
      MOT_RAMPDN = 2'b10
   } eas_motor_t;
endpackage

//--- verilog/eas_top.sv
// Event/action sequencer with timer 0 and start/stop handling.
// Assumes synchronous digital inputs and a simple strobe register port.
`timescale 1ns/1ns
`default_nettype none
module eas_top #(
   parameter int SCAN_CYCLES = eas_pkg::SCAN_CYC
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   input wire logic di_start,
   input wire logic di_stop,
   input wire logic at_reference,
   input wire logic ramp_done,
   output logic preset_sel,
   output logic run_cmd,
   output logic ramp_down,
   output logic coast,
   output logic action_pulse
);
   localparam logic [4:0] LAST = 5'(eas_pkg::MAX_PAIRS - 1);

   logic enable_q;
   logic [4:0] npairs_q;
   logic [31:0] tmr0_len_q;
   logic [3:0] di18_q, di27_q;
   logic [7:0] ev_mem [eas_pkg::MAX_PAIRS];
   logic [7:0] act_mem [eas_pkg::MAX_PAIRS];
   logic [4:0] ptr_q;
   logic [31:0] scan_cnt_q;
   logic scan_tick_q;
   logic [31:0] tmr0_cnt_q;
   logic tmr0_run_q, tmr0_exp_q;
   logic ev_true;
   logic fire;
   logic [7:0] cur_act;
   logic start_lvl_q, start_latch_q;
   logic stop_req;
   eas_pkg::eas_motor_t mot_q;
   logic [31:0] rd_d;
   logic wr_ev, wr_act;
   logic [7:0] ev_off, act_off;
   logic ev_hit, act_hit;

   // Below its base an array offset wraps high, so it never hits
   assign ev_off = addr - eas_pkg::A_EVENT0;
   assign act_off = addr - eas_pkg::A_ACTION0;
   assign ev_hit = ev_off[7:2] < 6'(eas_pkg::MAX_PAIRS);
   assign act_hit = act_off[7:2] < 6'(eas_pkg::MAX_PAIRS);
   assign wr_ev = wr_en && ev_hit;
   assign wr_act = wr_en && act_hit;

   // Control registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         enable_q <= 1'b0;
         npairs_q <= 5'h00;
         tmr0_len_q <= 32'h0000_0000;
         di18_q <= eas_pkg::DI18_RST;
         di27_q <= eas_pkg::DI27_RST;
      end else if (wr_en) begin
         if (addr == eas_pkg::A_CTRL) begin
            enable_q <= wdata[0];
            // Counts above twenty are clamped
            npairs_q <= (wdata[12:8] > 5'(eas_pkg::MAX_PAIRS)) ?
                        5'(eas_pkg::MAX_PAIRS) : wdata[12:8];
         end
         if (addr == eas_pkg::A_TMR0)
            tmr0_len_q <= wdata;
         if (addr == eas_pkg::A_DI_FUNC) begin
            di18_q <= wdata[3:0];
            di27_q <= wdata[7:4];
         end
      end
   end

   // Pair arrays; no reset, software programs them before enabling
   always_ff @(posedge mclk) begin
      if (wr_ev)
         ev_mem[ev_off[6:2]] <= wdata[7:0];
      if (wr_act)
         act_mem[act_off[6:2]] <= wdata[7:0];
   end

   // Scan interval divider
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         scan_cnt_q <= 32'h0000_0000;
         scan_tick_q <= 1'b0;
      end else if (scan_cnt_q >= 32'(SCAN_CYCLES - 1)) begin
         scan_cnt_q <= 32'h0000_0000;
         scan_tick_q <= 1'b1;
      end else begin
         scan_cnt_q <= scan_cnt_q + 32'h0000_0001;
         scan_tick_q <= 1'b0;
      end
   end

   // Only the current pair's event is decoded
   always_comb begin
      unique case (ev_mem[ptr_q])
         eas_pkg::EV_TRUE: ev_true = 1'b1;
         eas_pkg::EV_ON_REF: ev_true = at_reference;
         eas_pkg::EV_TIMEOUT0: ev_true = tmr0_exp_q;
         default: ev_true = 1'b0;
      endcase
   end

   assign fire = enable_q && scan_tick_q && npairs_q != 5'h00 &&
                 ev_true;
   assign cur_act = act_mem[ptr_q];

   // Pair pointer
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n)
         ptr_q <= 5'h00;
      else if (!enable_q)
         ptr_q <= 5'h00;
      else if (fire) begin
         if (ptr_q >= npairs_q - 5'h01 || ptr_q == LAST)
            ptr_q <= 5'h00;
         else
            ptr_q <= ptr_q + 5'h01;
      end
   end

   // Actions
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         preset_sel <= 1'b0;
         action_pulse <= 1'b0;
      end else begin
         action_pulse <= fire;
         if (fire) begin
            unique case (cur_act)
               eas_pkg::ACT_PRESET0: preset_sel <= 1'b0;
               eas_pkg::ACT_PRESET1: preset_sel <= 1'b1;
               default: preset_sel <= preset_sel;
            endcase
         end
      end
   end

   // Timer 0
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tmr0_cnt_q <= 32'h0000_0000;
         tmr0_run_q <= 1'b0;
         tmr0_exp_q <= 1'b0;
      end else if (fire && cur_act == eas_pkg::ACT_TIMER0) begin
         tmr0_cnt_q <= tmr0_len_q;
         tmr0_run_q <= 1'b1;
         tmr0_exp_q <= 1'b0;
      end else if (tmr0_run_q) begin
         if (tmr0_cnt_q == 32'h0000_0000) begin
            tmr0_run_q <= 1'b0;
            tmr0_exp_q <= 1'b1;
         end else
            tmr0_cnt_q <= tmr0_cnt_q - 32'h0000_0001;
      end
   end

   // Start/stop inputs
   assign stop_req = (di18_q == eas_pkg::DI_START && !di_start) ||
                     (di27_q == eas_pkg::DI_STOP_INV && !di_stop);
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         start_lvl_q <= 1'b0;
         start_latch_q <= 1'b0;
      end else begin
         start_lvl_q <= di_start;
         if (stop_req)
            start_latch_q <= 1'b0;
         else if (di18_q == eas_pkg::DI_LATCH_START && di_start &&
                  !start_lvl_q)
            start_latch_q <= 1'b1;
      end
   end

   // Motor state
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n)
         mot_q <= eas_pkg::MOT_FREE;
      else begin
         unique case (mot_q)
            eas_pkg::MOT_FREE:
               if (!stop_req && ((di18_q == eas_pkg::DI_START && di_start) ||
                   start_latch_q))
                  mot_q <= eas_pkg::MOT_RUN;
            eas_pkg::MOT_RUN:
               if (stop_req || (di18_q == eas_pkg::DI_LATCH_START &&
                   !start_latch_q))
                  mot_q <= eas_pkg::MOT_RAMPDN;
            eas_pkg::MOT_RAMPDN:
               if (ramp_done)
                  mot_q <= eas_pkg::MOT_FREE;
            default: mot_q <= eas_pkg::MOT_FREE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         run_cmd <= 1'b0;
         ramp_down <= 1'b0;
         coast <= 1'b1;
      end else begin
         run_cmd <= mot_q == eas_pkg::MOT_RUN;
         ramp_down <= mot_q == eas_pkg::MOT_RAMPDN;
         coast <= mot_q == eas_pkg::MOT_FREE;
      end
   end

   // Read port
   always_comb begin
      rd_d = 32'h0000_0000;
      if (addr == eas_pkg::A_CTRL)
         rd_d = {19'h0_0000, npairs_q, 7'h00, enable_q};
      else if (addr == eas_pkg::A_STATUS)
         rd_d = {20'h0_0000, mot_q, tmr0_exp_q, tmr0_run_q, preset_sel,
                 2'b00, ptr_q};
      else if (addr == eas_pkg::A_TMR0)
         rd_d = tmr0_len_q;
      else if (addr == eas_pkg::A_DI_FUNC)
         rd_d = {24'h00_0000, di27_q, di18_q};
      else if (ev_hit)
         rd_d = {24'h00_0000, ev_mem[ev_off[6:2]]};
      else if (act_hit)
         rd_d = {24'h00_0000, act_mem[act_off[6:2]]};
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n)
         rdata <= 32'h0000_0000;
      else if (rd_en)
         rdata <= rd_d;
      else
         rdata <= 32'h0000_0000;
   end

   property p_disable_ptr;
      @(posedge mclk) disable iff (!arst_n)
      !enable_q |=> ptr_q == 5'h00;
   endproperty
   a_disable_ptr: assert property (p_disable_ptr)
      else $error("Pointer not cleared while disabled");

   property p_hold_false;
      @(posedge mclk) disable iff (!arst_n)
      enable_q && scan_tick_q && !ev_true |=> $stable(ptr_q);
   endproperty
   a_hold_false: assert property (p_hold_false)
      else $error("Pointer moved on false event");

   property p_advance;
      @(posedge mclk) disable iff (!arst_n)
      fire && ptr_q < npairs_q - 5'h01 |=> ptr_q == $past(ptr_q) + 5'h01;
   endproperty
   a_advance: assert property (p_advance)
      else $error("Pointer did not advance");

   property p_wrap;
      @(posedge mclk) disable iff (!arst_n)
      fire && ptr_q == npairs_q - 5'h01 |=> ptr_q == 5'h00;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("Sequence did not wrap");

   property p_only_on_tick;
      @(posedge mclk) disable iff (!arst_n)
      !scan_tick_q |=> $stable(ptr_q) || ptr_q == 5'h00;
   endproperty
   a_only_on_tick: assert property (p_only_on_tick)
      else $error("Pointer moved off scan tick");

   property p_ptr_range;
      @(posedge mclk) disable iff (!arst_n)
      ptr_q < 5'(eas_pkg::MAX_PAIRS);
   endproperty
   a_ptr_range: assert property (p_ptr_range)
      else $error("Pointer out of range");

   property p_preset1;
      @(posedge mclk) disable iff (!arst_n)
      fire && cur_act == eas_pkg::ACT_PRESET1 |=> preset_sel;
   endproperty
   a_preset1: assert property (p_preset1)
      else $error("Preset 1 not selected");

   sequence s_arm;
      fire && cur_act == eas_pkg::ACT_TIMER0;
   endsequence
   property p_timer_arm;
      @(posedge mclk) disable iff (!arst_n)
      s_arm |=> tmr0_run_q && !tmr0_exp_q;
   endproperty
   a_timer_arm: assert property (p_timer_arm)
      else $error("Timer 0 not armed");

   property p_stop_ramp;
      @(posedge mclk) disable iff (!arst_n)
      mot_q == eas_pkg::MOT_RUN && stop_req |=>
         mot_q == eas_pkg::MOT_RAMPDN ##1 ramp_down;
   endproperty
   a_stop_ramp: assert property (p_stop_ramp)
      else $error("Stop did not ramp down");

   property p_enable_gate;
      @(posedge mclk) disable iff (!arst_n)
      !enable_q |=> !action_pulse;
   endproperty
   a_enable_gate: assert property (p_enable_gate)
      else $error("Action while disabled");
endmodule
`default_nettype wire
